/* File: rtl/cco_map.vh */
// Register map, field layout and reset values of the clock output channel block
// Assumes byte addresses of four times the register index on a 32-bit bus
`ifndef CCO_MAP_VH
`define CCO_MAP_VH

`define CCO_ADDR_W       6
`define CCO_IDX_HI       5
`define CCO_IDX_LO       2
`define CCO_IDX_CH_FIRST 4'h0
`define CCO_IDX_CH_LAST  4'h7
`define CCO_IDX_BOOST    4'h9
`define CCO_IDX_GLOBAL   4'he
`define CCO_IDX_STATUS   4'hf

`define CCO_NUM_CH       8
`define CCO_MODE_HI      18
`define CCO_MODE_LO      17
`define CCO_EN_BIT       16
`define CCO_DIV_HI       15
`define CCO_DIV_LO       8
`define CCO_DLY_HI       7
`define CCO_DLY_LO       4
`define CCO_RESET_BIT    31
`define CCO_BOOST_BIT    16
`define CCO_SEL_BIT      28
`define CCO_GOE_BIT      27
`define CCO_PD_BIT       26

`define CCO_CH_MASK      32'h0007fff0
`define CCO_BOOST_MASK   32'h00010000
`define CCO_GLB_MASK     32'h1c000000
`define CCO_CH_DEFAULT   32'h00000100
`define CCO_BOOST_DEFAULT 32'h00000000
`define CCO_GLB_DEFAULT  32'h08000000

`define CCO_MODE_BYPASS  2'h0
`define CCO_MODE_DIV     2'h1
`define CCO_MODE_DLY     2'h2
`define CCO_MODE_DIVDLY  2'h3
`define CCO_DLY_TAPS     15

`define CCO_RESP_OKAY    2'h0
`define CCO_RESP_SLVERR  2'h2

`endif

/* File: rtl/cco_sync2.v */
// Two flip-flop synchroniser for a bundle of asynchronous pin levels
// Assumes each bit is an independent level; no bus coherence is kept
`timescale 1ns/10ps
module cco_sync2 #(
  parameter WIDTH = 4
) (
  clk_sys,
  srst,
  async_in,
  sync_out
);
  input  wire             clk_sys;
  input  wire             srst;
  input  wire [WIDTH-1:0] async_in;
  output wire [WIDTH-1:0] sync_out;

  reg [WIDTH-1:0] meta_reg;
  reg [WIDTH-1:0] stable_reg;

  // Only the second stage is read outside
  always @(posedge clk_sys) begin
    if (srst) begin
      meta_reg   <= {WIDTH{1'b0}};
      stable_reg <= {WIDTH{1'b0}};
    end else begin
      meta_reg   <= async_in;
      stable_reg <= meta_reg;
    end
  end

  assign sync_out = stable_reg;
endmodule

/* File: rtl/cco_channel.v */
// One output channel: even divider, tapped delay line, path select and gating
// Assumes clock_level and clock_rise are already in the clk_sys domain
`timescale 1ns/10ps
`include "cco_map.vh"
module cco_channel (
  clk_sys,
  srst,
  clock_level,
  clock_rise,
  restart,
  path_mode,
  divide_code,
  delay_code,
  output_allowed,
  clock_out,
  divide_pending
);
  input  wire       clk_sys;
  input  wire       srst;
  input  wire       clock_level;
  input  wire       clock_rise;
  input  wire       restart;
  input  wire [1:0] path_mode;
  input  wire [7:0] divide_code;
  input  wire [3:0] delay_code;
  input  wire       output_allowed;
  output wire       clock_out;
  output wire       divide_pending;

  reg  [7:0]                cnt_reg;
  reg                       div_reg;
  reg  [7:0]                code_prev_reg;
  reg                       pending_reg;
  reg  [`CCO_DLY_TAPS-1:0]  dly_reg;
  reg                       out_reg;
  wire                      path_div;
  wire [`CCO_DLY_TAPS:0]    taps;
  wire                      path_sel;
  wire [31:0]               reset_word;

  // Toggle every divide_code input rises; code 0 freezes the divider output at its current level
  always @(posedge clk_sys) begin
    if (srst || restart) begin
      cnt_reg <= 8'h00;
      div_reg <= 1'b0;
    end else if (clock_rise && (divide_code != 8'h00)) begin
      // Toggling at count zero puts the first edge of every code on one rise
      if (cnt_reg == 8'h00)
        div_reg <= ~div_reg;
      // A compare by >= stops a shrunk code from running the counter away
      if (cnt_reg >= divide_code - 8'h01)
        cnt_reg <= 8'h00;
      else
        cnt_reg <= cnt_reg + 8'h01;
    end
  end

  assign reset_word = `CCO_CH_DEFAULT;

  // A changed code stays flagged until the next restart; the set wins
  always @(posedge clk_sys) begin
    if (srst) begin
      code_prev_reg <= reset_word[`CCO_DIV_HI:`CCO_DIV_LO];
      pending_reg   <= 1'b0;
    end else begin
      code_prev_reg <= divide_code;
      if (divide_code != code_prev_reg)
        pending_reg <= 1'b1;
      else if (restart)
        pending_reg <= 1'b0;
    end
  end

  assign path_div = path_mode[0] ? div_reg : clock_level;
  assign taps     = {dly_reg, path_div};
  assign path_sel = path_mode[1] ? taps[delay_code] : path_div;

  always @(posedge clk_sys) begin
    if (srst) begin
      dly_reg <= {`CCO_DLY_TAPS{1'b0}};
      out_reg <= 1'b0;
    end else begin
      dly_reg <= taps[`CCO_DLY_TAPS-1:0];
      out_reg <= output_allowed & path_sel;
    end
  end

  assign clock_out      = out_reg;
  assign divide_pending = pending_reg;
endmodule

/* File: rtl/cco_top.v */
// Eight-channel clock output control: AXI4-Lite registers and channel paths
// Assumes clock, sync and enable pins are asynchronous and sampled on clk_sys
//
// What this block does
// - Eight identical channel control registers, one per output; first also holds reset.
// - Channel fields: mode 18:17, enable 16, divide 15:8, delay 7:4; defaults set.
// - Reset bit 31 of first channel register restores all defaults, clearing itself.
// - A write setting reset ignores its other fields; host rewrites afterwards.
// - Path mode 0 bypass, 1 divided, 2 delayed, 3 divided and delayed.
// - Divider matters only in divided or divided-and-delayed modes.
// - Divide by twice the code; code 0 invalid, default code 1.
// - Global bit 28 selects input: 0 second input, 1 first input.
// - Global bit 27 is global output enable, default 1.
// - Global bit 26 is power-down, default 0.
// - Global enable bit or pin low disables all outputs; else per-channel enable.
// - Power-down stops the whole device regardless of other bits or pins.
// - Delay code matters only in delayed or divided-and-delayed modes.
//
// Register access over AXI4-Lite was left to the implementer.
`timescale 1ns/10ps
`include "cco_map.vh"
module cco_top (
  clk_sys,
  srst,
  s_axi_awaddr,
  s_axi_awvalid,
  s_axi_awready,
  s_axi_wdata,
  s_axi_wstrb,
  s_axi_wvalid,
  s_axi_wready,
  s_axi_bresp,
  s_axi_bvalid,
  s_axi_bready,
  s_axi_araddr,
  s_axi_arvalid,
  s_axi_arready,
  s_axi_rdata,
  s_axi_rresp,
  s_axi_rvalid,
  s_axi_rready,
  first_clock_input,
  second_clock_input,
  sync_n,
  global_enable_pin,
  channel_clock_out,
  output_boost_enable,
  device_power_down
);
  input  wire                    clk_sys;
  input  wire                    srst;
  input  wire [`CCO_ADDR_W-1:0]  s_axi_awaddr;
  input  wire                    s_axi_awvalid;
  output wire                    s_axi_awready;
  input  wire [31:0]             s_axi_wdata;
  input  wire [3:0]              s_axi_wstrb;
  input  wire                    s_axi_wvalid;
  output wire                    s_axi_wready;
  output wire [1:0]              s_axi_bresp;
  output wire                    s_axi_bvalid;
  input  wire                    s_axi_bready;
  input  wire [`CCO_ADDR_W-1:0]  s_axi_araddr;
  input  wire                    s_axi_arvalid;
  output wire                    s_axi_arready;
  output wire [31:0]             s_axi_rdata;
  output wire [1:0]              s_axi_rresp;
  output wire                    s_axi_rvalid;
  input  wire                    s_axi_rready;
  input  wire                    first_clock_input;
  input  wire                    second_clock_input;
  input  wire                    sync_n;
  input  wire                    global_enable_pin;
  output wire [`CCO_NUM_CH-1:0]  channel_clock_out;
  output wire                    output_boost_enable;
  output wire                    device_power_down;

  // ***************************************************************
  // Byte-lane merge
  // ***************************************************************
  function [31:0] merge_word;
    input [31:0] old_word;
    input [31:0] new_word;
    input [3:0]  strb;
    input [31:0] mask;
    integer      b;
    reg   [31:0] res;
    begin
      res = old_word;
      for (b = 0; b < 4; b = b + 1) begin
        if (strb[b])
          res[8*b +: 8] = new_word[8*b +: 8];
      end
      merge_word = res & mask;
    end
  endfunction

  // ***************************************************************
  // Pin synchronisers
  // ***************************************************************
  wire [3:0] pins_s;
  wire       first_s;
  wire       second_s;
  wire       sync_n_s;
  wire       goe_pin_s;

  cco_sync2 #(
    .WIDTH (4)
  ) u_pin_sync (
    .clk_sys  (clk_sys),
    .srst     (srst),
    .async_in ({global_enable_pin, sync_n, second_clock_input, first_clock_input}),
    .sync_out (pins_s)
  );

  assign first_s   = pins_s[0];
  assign second_s  = pins_s[1];
  assign sync_n_s  = pins_s[2];
  assign goe_pin_s = pins_s[3];

  // ***************************************************************
  // Write channel
  // ***************************************************************
  reg                    aw_held_reg;
  reg [`CCO_ADDR_W-1:0]  awaddr_reg;
  reg                    w_held_reg;
  reg [31:0]             wdata_reg;
  reg [3:0]              wstrb_reg;
  reg                    bvalid_reg;
  reg [1:0]              bresp_reg;
  wire                   do_write;
  wire [3:0]             wr_idx;
  wire                   wr_is_ch;
  wire                   wr_mapped;
  wire                   soft_reset;
  wire                   wr_first;
  reg                    wr_hit_ch;
  reg                    wr_hit_boost;
  reg                    wr_hit_glb;

  // Address and data are taken in either order; one write in flight
  assign s_axi_awready = ~aw_held_reg & ~bvalid_reg;
  assign s_axi_wready  = ~w_held_reg & ~bvalid_reg;
  assign do_write      = aw_held_reg & w_held_reg & ~bvalid_reg;
  assign wr_idx        = awaddr_reg[`CCO_IDX_HI:`CCO_IDX_LO];
  assign wr_is_ch      = wr_hit_ch;
  assign wr_mapped     = wr_hit_ch | wr_hit_boost | wr_hit_glb;
  assign wr_first      = wr_is_ch & (wr_idx == `CCO_IDX_CH_FIRST);
  assign soft_reset    = do_write & wr_first & wstrb_reg[3] & wdata_reg[`CCO_RESET_BIT];

  always @(posedge clk_sys) begin
    if (srst) begin
      aw_held_reg <= 1'b0;
      awaddr_reg  <= {`CCO_ADDR_W{1'b0}};
      w_held_reg  <= 1'b0;
      wdata_reg   <= 32'h00000000;
      wstrb_reg   <= 4'h0;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= `CCO_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_reg <= 1'b1;
        awaddr_reg  <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_reg <= 1'b1;
        wdata_reg  <= s_axi_wdata;
        wstrb_reg  <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_held_reg <= 1'b0;
        w_held_reg  <= 1'b0;
        bvalid_reg  <= 1'b1;
        bresp_reg   <= wr_mapped ? `CCO_RESP_OKAY : `CCO_RESP_SLVERR;
      end else if (bvalid_reg && s_axi_bready) begin
        bvalid_reg <= 1'b0;
      end
    end
  end

  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp  = bresp_reg;

  // ***************************************************************
  // Write decode
  // ***************************************************************
  // Reserved slots raise no strobe, so their writes answer with an error
  always @* begin
    wr_hit_ch    = 1'b0;
    wr_hit_boost = 1'b0;
    wr_hit_glb   = 1'b0;
    case (wr_idx)
      `CCO_IDX_BOOST:  wr_hit_boost = 1'b1;
      `CCO_IDX_GLOBAL: wr_hit_glb   = 1'b1;
      default:         wr_hit_ch    = (wr_idx <= `CCO_IDX_CH_LAST);
    endcase
  end

  // ***************************************************************
  // Global and boost registers
  // ***************************************************************
  reg  [31:0] glb_reg;
  reg  [31:0] boost_reg;
  wire        sel_first;
  wire        glb_enable;
  wire        power_down;

  always @(posedge clk_sys) begin
    if (srst || soft_reset) begin
      glb_reg   <= `CCO_GLB_DEFAULT;
      boost_reg <= `CCO_BOOST_DEFAULT;
    end else if (do_write) begin
      if (wr_hit_glb)
        glb_reg <= merge_word(glb_reg, wdata_reg, wstrb_reg, `CCO_GLB_MASK);
      if (wr_hit_boost)
        boost_reg <= merge_word(boost_reg, wdata_reg, wstrb_reg, `CCO_BOOST_MASK);
    end
  end

  assign sel_first           = glb_reg[`CCO_SEL_BIT];
  assign glb_enable          = glb_reg[`CCO_GOE_BIT];
  assign power_down          = glb_reg[`CCO_PD_BIT];
  assign output_boost_enable = boost_reg[`CCO_BOOST_BIT];
  assign device_power_down   = power_down;

  // ***************************************************************
  // Selected input clock and restart
  // ***************************************************************
  reg  sel_prev_reg;
  wire sel_level;
  wire sel_rise;
  wire restart;

  assign sel_level = sel_first ? first_s : second_s;

  always @(posedge clk_sys) begin
    if (srst)
      sel_prev_reg <= 1'b0;
    else
      sel_prev_reg <= sel_level;
  end

  assign sel_rise = sel_level & ~sel_prev_reg;
  // Dividers hold at phase zero while sync is low and start together on release
  assign restart  = ~sync_n_s | power_down;

  // ***************************************************************
  // Channel registers and paths
  // ***************************************************************
  wire [32*`CCO_NUM_CH-1:0] ch_flat;
  wire [`CCO_NUM_CH-1:0]    ch_allowed;
  wire [`CCO_NUM_CH-1:0]    ch_pending;
  wire [`CCO_NUM_CH-1:0]    ch_write;

  genvar i;
  generate
    for (i = 0; i < `CCO_NUM_CH; i = i + 1) begin : chan
      reg [31:0] ctrl_reg;

      // One strobe per channel keeps the index compare out of the register
      assign ch_write[i] = do_write & wr_is_ch & (wr_idx == i);

      // A reset write leaves its own other fields unused
      always @(posedge clk_sys) begin
        if (srst || soft_reset) begin
          ctrl_reg <= `CCO_CH_DEFAULT;
        end else if (ch_write[i]) begin
          ctrl_reg <= merge_word(ctrl_reg, wdata_reg, wstrb_reg, `CCO_CH_MASK);
        end
      end

      assign ch_flat[32*i +: 32] = ctrl_reg;
      assign ch_allowed[i] = ~power_down & glb_enable & goe_pin_s & ctrl_reg[`CCO_EN_BIT];

      cco_channel u_channel (
        .clk_sys        (clk_sys),
        .srst           (srst),
        .clock_level    (sel_level),
        .clock_rise     (sel_rise),
        .restart        (restart),
        .path_mode      (ctrl_reg[`CCO_MODE_HI:`CCO_MODE_LO]),
        .divide_code    (ctrl_reg[`CCO_DIV_HI:`CCO_DIV_LO]),
        .delay_code     (ctrl_reg[`CCO_DLY_HI:`CCO_DLY_LO]),
        .output_allowed (ch_allowed[i]),
        .clock_out      (channel_clock_out[i]),
        .divide_pending (ch_pending[i])
      );
    end
  endgenerate

  // ***************************************************************
  // Status word
  // ***************************************************************
  wire [31:0] status_word;

  // Live view: allowed outputs, codes awaiting sync, sync and enable pins
  assign status_word = {14'h0000, goe_pin_s, ~sync_n_s, ch_pending, ch_allowed};

  // ***************************************************************
  // Read channel
  // ***************************************************************
  reg         rvalid_reg;
  reg  [31:0] rdata_reg;
  reg  [1:0]  rresp_reg;
  reg  [31:0] rd_word;
  reg  [1:0]  rd_resp;
  wire [3:0]  rd_idx;

  assign rd_idx        = s_axi_araddr[`CCO_IDX_HI:`CCO_IDX_LO];
  assign s_axi_arready = ~rvalid_reg;

  // Reset bit never reads back set since CCO_CH_MASK keeps bit 31 out of the register
  always @* begin
    rd_word = 32'h00000000;
    rd_resp = `CCO_RESP_OKAY;
    case (rd_idx)
      `CCO_IDX_BOOST:  rd_word = boost_reg;
      `CCO_IDX_GLOBAL: rd_word = glb_reg;
      `CCO_IDX_STATUS: rd_word = status_word;
      default: begin
        if (rd_idx <= `CCO_IDX_CH_LAST)
          rd_word = ch_flat[32*rd_idx +: 32];
        else
          rd_resp = `CCO_RESP_SLVERR;
      end
    endcase
  end

  always @(posedge clk_sys) begin
    if (srst) begin
      rvalid_reg <= 1'b0;
      rdata_reg  <= 32'h00000000;
      rresp_reg  <= `CCO_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rvalid_reg <= 1'b1;
      rdata_reg  <= rd_word;
      rresp_reg  <= rd_resp;
    end else if (rvalid_reg && s_axi_rready) begin
      rvalid_reg <= 1'b0;
    end
  end

  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata  = rdata_reg;
  assign s_axi_rresp  = rresp_reg;
endmodule

/* File: dv/cco_top_assertions.sv */
// Port checks of the clock output control block
// Assumes a bind to cco_top; sees only its ports
`timescale 1ns/10ps
module cco_top_assertions (
  input wire        clk_sys,
  input wire        srst,
  input wire        s_axi_awvalid,
  input wire        s_axi_awready,
  input wire        s_axi_wvalid,
  input wire        s_axi_wready,
  input wire [1:0]  s_axi_bresp,
  input wire        s_axi_bvalid,
  input wire        s_axi_bready,
  input wire [5:0]  s_axi_araddr,
  input wire        s_axi_arvalid,
  input wire        s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire [1:0]  s_axi_rresp,
  input wire        s_axi_rvalid,
  input wire        s_axi_rready,
  input wire        global_enable_pin,
  input wire [7:0]  channel_clock_out,
  input wire        device_power_down
);
  // ******
  // Checks
  // ******
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (srst);
  sequence s_wr_take;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_wr_busy;
    !s_axi_awready && !s_axi_wready ##1 s_axi_bvalid;
  endsequence
  sequence s_rd_take;
    s_axi_arvalid && s_axi_arready;
  endsequence
  AST_WR_ANSWER: assert property (s_wr_take |=> s_wr_busy)
    else $error("write answer out of time");
  AST_WR_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  AST_RD_ANSWER: assert property (s_rd_take |=> s_axi_rvalid)
    else $error("read answer late");
  AST_RD_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  AST_RD_BUSY: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("second read taken");
  AST_RD_UNMAPPED: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr[5:2] == 4'h8
    |=> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0)
    else $error("unmapped read answered");
  // Reset bit and unused bits must never read back as set
  AST_RD_FIELDS: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr[5:2] <= 4'h7
    |=> s_axi_rresp == 2'h0 && (s_axi_rdata & 32'hfff8000f) == 32'h0)
    else $error("channel read has stray bits");
  AST_RST_IDLE: assert property ($fell(srst) |-> !s_axi_bvalid && !s_axi_rvalid && channel_clock_out == 8'h00)
    else $error("not idle after reset");
  AST_PD_QUIET: assert property (device_power_down [*3] |-> channel_clock_out == 8'h00)
    else $error("output runs in power down");
  // Five cycles cover the pin synchroniser and the output register
  AST_PIN_QUIET: assert property (!global_enable_pin [*5] |-> channel_clock_out == 8'h00)
    else $error("output runs with pin low");
endmodule
bind cco_top cco_top_assertions u_cco_chk (
  .clk_sys(clk_sys), .srst(srst), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .global_enable_pin(global_enable_pin), .channel_clock_out(channel_clock_out),
  .device_power_down(device_power_down)
);

/* File: dv/cco_clock_partner.sv */
// Far side model: two source clocks and a receiver timing each output
// Assumes periods are whole clk_sys multiples so sampled edges are regular
`timescale 1ns/10ps
module cco_clock_partner (
  output logic    first_clock_input,
  output logic    second_clock_input,
  input  wire [7:0] channel_clock_out,
  output realtime last_rise [8],
  output realtime rise_gap [8],
  output int      rise_cnt [8]
);
  // ********
  // Sources
  // ********
  initial begin
    first_clock_input = 1'b0;
    second_clock_input = 1'b0;
    #3;
    forever #40 second_clock_input = ~second_clock_input;
  end
  always #24 first_clock_input = ~first_clock_input;
  for (genvar i = 0; i < 8; i++) begin : g_rx
    initial begin
      rise_cnt[i] = 0;
      last_rise[i] = 0.0;
      rise_gap[i] = 0.0;
    end
    always @(posedge channel_clock_out[i]) begin
      rise_gap[i] = $realtime - last_rise[i];
      last_rise[i] = $realtime;
      rise_cnt[i] = rise_cnt[i] + 1;
    end
  end
endmodule

/* File: dv/test_clock_output_channel_config.sv */
// Self-checking bench for the clock output control block
// Assumes cco_top, its bound checker and the clock partner model
`timescale 1ns/10ps
module test_clock_output_channel_config;
  // ********
  // Signals
  // ********
  logic        clk_sys = 1'b0;
  logic        srst = 1'b1;
  logic [5:0]  s_axi_awaddr = 6'h00;
  logic        s_axi_awvalid = 1'b0;
  logic [31:0] s_axi_wdata = 32'h0;
  logic        s_axi_wvalid = 1'b0;
  logic        s_axi_bready = 1'b0;
  logic [5:0]  s_axi_araddr = 6'h00;
  logic        s_axi_arvalid = 1'b0;
  logic        s_axi_rready = 1'b0;
  logic        sync_n = 1'b1;
  logic        global_enable_pin = 1'b1;
  wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire  [1:0]  s_axi_bresp, s_axi_rresp;
  wire  [31:0] s_axi_rdata;
  wire         first_clock_input, second_clock_input, output_boost_enable, device_power_down;
  wire  [7:0]  channel_clock_out;
  realtime     last_rise [8];
  realtime     rise_gap [8];
  int          rise_cnt [8];
  int          fail_count = 0;
  int          check_count = 0;
  int          cycles = 0;
  logic [31:0] seed = 32'h8fa0e142;
  logic [31:0] d;
  logic [1:0]  md [8] = '{2'h0, 2'h2, 2'h2, 2'h3, 2'h1, 2'h1, 2'h1, 2'h0};
  int          cd [8] = '{1, 1, 1, 1, 1, 0, 2, 5};
  int          dl [8] = '{0, 2, 5, 3, 0, 0, 0, 0};
  logic        en [8] = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b1};
  cco_top dut (
    .clk_sys(clk_sys), .srst(srst), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'hf),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .first_clock_input(first_clock_input), .second_clock_input(second_clock_input),
    .sync_n(sync_n), .global_enable_pin(global_enable_pin), .channel_clock_out(channel_clock_out),
    .output_boost_enable(output_boost_enable), .device_power_down(device_power_down)
  );
  cco_clock_partner u_partner (
    .first_clock_input(first_clock_input), .second_clock_input(second_clock_input),
    .channel_clock_out(channel_clock_out), .last_rise(last_rise), .rise_gap(rise_gap),
    .rise_cnt(rise_cnt)
  );
  always #4 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      $display("[FAIL] %0t timeout", $time);
      fail_count++;
      test_done();
    end
  end
  task automatic test_done();
    if (fail_count == 0 && check_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  function automatic logic [31:0] cw(input int i);
    return {13'h0, md[i], en[i], 8'(cd[i]), 4'(dl[i]), 4'h0};
  endfunction
  // Divide code zero gives no clock in the divided modes
  function automatic logic run_of(input int i);
    return en[i] && (!md[i][0] || cd[i] != 0);
  endfunction
  function automatic logic [7:0] run_mask();
    for (int i = 0; i < 8; i++) run_mask[i] = run_of(i);
  endfunction
  function automatic int exp_gap(input int i, input int tin);
    return md[i][0] ? 2 * cd[i] * tin : tin;
  endfunction
  function automatic int wrap(input realtime t, input int p);
    int x;
    x = int'(t) % p;
    return x < 0 ? x + p : x;
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // Address and data go out together; bready stands until the answer
  task automatic wrc(input logic [5:0] a, input logic [31:0] v, input logic [1:0] er);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge clk_sys);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    chk(s_axi_bresp, er);
    s_axi_bready <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic rdc(input logic [5:0] a, input logic [31:0] e, input logic [1:0] er);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge clk_sys); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge clk_sys); while (!s_axi_rvalid);
    chk(s_axi_rdata, e);
    chk(s_axi_rresp, er);
    s_axi_rready <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic runchk(input logic [7:0] exp_run);
    int         c0 [8];
    logic [7:0] got;
    repeat (8) @(posedge clk_sys);
    c0 = rise_cnt;
    repeat (400) @(posedge clk_sys);
    for (int i = 0; i < 8; i++) got[i] = rise_cnt[i] != c0[i];
    chk(got, exp_run);
  endtask
  task automatic measure(input int tin);
    runchk(run_mask());
    for (int i = 0; i < 8; i++) begin
      if (run_of(i)) chk(int'(rise_gap[i]), exp_gap(i, tin));
    end
    chk(wrap(last_rise[2] - last_rise[1], tin), (dl[2] - dl[1]) * 8);
  endtask
  // ******
  // Tests
  // ******
  initial begin
    repeat (5) @(posedge clk_sys);
    srst <= 1'b0;
    for (int i = 0; i < 8; i++) rdc(6'(4 * i), 32'h100, 2'h0);
    rdc(6'h24, 32'h0, 2'h0);
    rdc(6'h38, 32'h08000000, 2'h0);
    rdc(6'h20, 32'h0, 2'h2);
    wrc(6'h2c, rnd(), 2'h2);
    for (int i = 0; i < 8; i++) begin
      d = rnd() & 32'h7fffffff;
      wrc(6'(4 * i), d, 2'h0);
      rdc(6'(4 * i), d & 32'h0007fff0, 2'h0);
    end
    d = rnd();
    wrc(6'h38, d, 2'h0);
    rdc(6'h38, d & 32'h1c000000, 2'h0);
    chk(device_power_down, d[26]);
    wrc(6'h24, d, 2'h0);
    rdc(6'h24, d & 32'h00010000, 2'h0);
    chk(output_boost_enable, d[16]);
    wrc(6'h00, rnd() | 32'h80000000, 2'h0);
    for (int i = 0; i < 8; i++) rdc(6'(4 * i), 32'h100, 2'h0);
    rdc(6'h24, 32'h0, 2'h0);
    rdc(6'h38, 32'h08000000, 2'h0);
    cd[3] = 1 + rnd() % 4;
    cd[4] = 1 + rnd() % 4;
    for (int i = 0; i < 8; i++) wrc(6'(4 * i), cw(i), 2'h0);
    measure(80);
    wrc(6'h38, 32'h18000000, 2'h0);
    measure(48);
    wrc(6'h38, 32'h10000000, 2'h0);
    runchk(8'h00);
    wrc(6'h38, 32'h1c000000, 2'h0);
    chk(device_power_down, 1'b1);
    runchk(8'h00);
    wrc(6'h38, 32'h18000000, 2'h0);
    global_enable_pin <= 1'b0;
    runchk(8'h00);
    global_enable_pin <= 1'b1;
    md[0] = 2'h1;
    md[1] = 2'h1;
    cd[1] = 2;
    wrc(6'h00, cw(0), 2'h0);
    wrc(6'h04, cw(1), 2'h0);
    sync_n <= 1'b0;
    repeat (8) @(posedge clk_sys);
    sync_n <= 1'b1;
    runchk(run_mask());
    chk(wrap(last_rise[1] - last_rise[0], exp_gap(0, 48)), 0);
    test_done();
  end
endmodule
